// ===== dv/dioc_checker.sv
// Purpose: Bus and pin checks at the top of the I/O channel controller.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every dioc_top instance at the foot of this file.
`timescale 1ns/1ps
module dioc_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_level_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_out,
  input wire logic [15:0] led_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Both write halves taken at one edge start the response timer.
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // The pin path is two sync stages plus a register, so five is ample;
  // reset must stay off throughout, since it clears the sync stages.
  sequence pins_steady_s;
    (!rst_in && $stable(pin_level_in)) [*5];
  endsequence
  high_side_a: assert property (pin_oe_out == pin_out)
    else $error("pin enable differs from drive level");
  led_raw_a: assert property (
    pins_steady_s |-> led_out == pin_level_in)
    else $error("indicator does not follow the pin");
  bresp_time_a: assert property (wr_both_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rresp_time_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  wr_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
endmodule // dioc_checker

bind dioc_top dioc_checker i_chk (.clk_in, .rst_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_level_in, .pin_out, .pin_oe_out, .led_out);

// ===== dv/dioc_plc_model.sv
// Purpose: Cyclic controller model that moves process data over the bus.
// Assumes: One write or one read at a time, driven right after a clock edge.
// Notes: Released payload is inverted so a stale value is never reused.
`timescale 1ns/1ps
module dioc_plc_model (
  input wire logic clk_in,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero; whole words are always written.
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
  end
  // Valid and response ready rise together; each channel drops when taken,
  // and the response is taken at the edge that samples bvalid high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic hs;
    hs = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hs) begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      hs = s_axi_bvalid && s_axi_bready;
      if (hs) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  // Read with ready raised beside the address and held until data comes.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic hs;
    hs = 1'b0;
    @(posedge clk_in);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hs) begin
      @(posedge clk_in);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
      end
      hs = s_axi_rvalid && s_axi_rready;
      if (hs) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
endmodule // dioc_plc_model

// ===== dv/tb.sv
// Purpose: Self-checking bench for the digital I/O channel controller.
// Assumes: The controller model drives the bus; pins are driven here.
// Notes: Long fault timers are not reached; a short fault must stay silent.
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [15:0] ctl; logic [15:0] pin;} dioc_row_type;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] pin_level_in, out_overload_in, out_overcurrent_in;
  logic [15:0] pin_out, pin_oe_out, led_out;
  logic [7:0] sensor_short_in;
  logic sensor_supply_undervoltage_in, actuator_supply_undervoltage_in;
  logic internal_fault_flag_in, link_lost_in, forcing_active_flag_in;
  int fails = 0;
  int total_checks = 0;
  dioc_row_type rows [4] = '{'{16'h0001, 16'h8000}, '{16'h8000, 16'h0001},
    '{16'hA5C3, 16'h3C5A}, '{16'h0018, 16'h0000}};
  logic [7:0] gbit [4] = '{8'h01, 8'h02, 8'h80, 8'h40};
  // A 40 ns period gives the 25 MHz module clock.
  always #20 clk_in = ~clk_in;
  dioc_top i_dut (.clk_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pin_level_in, .out_overload_in, .out_overcurrent_in, .sensor_short_in,
    .sensor_supply_undervoltage_in, .actuator_supply_undervoltage_in,
    .internal_fault_flag_in, .link_lost_in, .forcing_active_flag_in,
    .pin_out, .pin_oe_out, .led_out);
  dioc_plc_model i_plc (.clk_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Comparison, bus and settling helpers shared by every test.
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_plc.wr(a, d, r);
    chk("write response", 32'h0, {30'h0, r});
  endtask
  // Polls a bounded number of reads, since sync latency is not fixed.
  task automatic rchk(input string s, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      i_plc.rd(a, v, r);
      n++;
    end while ((v & m) !== e && n < 8);
    chk(s, e, v & m);
  endtask
  task automatic settle(input logic [15:0] p, input logic [15:0] l);
    int n;
    n = 0;
    while ((pin_out !== p || led_out !== l) && n < 40) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog sized well beyond the longest filter wait.
  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    wrap_up;
  end
  // Main sequence: reset checks, then table rows, then the awkward cases.
  initial begin
    pin_level_in = 16'hFFFF;
    {out_overload_in, out_overcurrent_in, sensor_short_in} = '0;
    {sensor_supply_undervoltage_in, actuator_supply_undervoltage_in} = 2'h0;
    {internal_fault_flag_in, link_lost_in, forcing_active_flag_in} = 3'h0;
    repeat (8) @(posedge clk_in);
    chk("reset outputs", 32'h0, {pin_out, led_out});
    rst_in <= 1'b0;
    rchk("channel config", dioc_pkg::A_CH0, dioc_pkg::CH_RST, '1);
    rchk("map identity", dioc_pkg::A_MAP0 + 8'h0C, 32'h3, '1);
    $display("Test reset done");
    wr(dioc_pkg::A_CTRL, 32'h1);
    foreach (rows[i]) begin
      wr(dioc_pkg::A_CONS, {16'h0000, rows[i].ctl});
      pin_level_in <= rows[i].pin;
      settle(rows[i].ctl, rows[i].pin);
      chk("pin drive", rows[i].ctl, pin_out);
      chk("pin enable", rows[i].ctl, pin_oe_out);
      chk("led", rows[i].pin, led_out);
      rchk("input status", dioc_pkg::A_PROD0, rows[i].pin, '1);
      $display("Test row %0d done", i);
    end
    wr(dioc_pkg::A_CH0 + 8'h04, 32'h5);
    wr(dioc_pkg::A_CH0 + 8'h0C, 32'h8);
    for (int k = 0; k < 3; k++) begin
      link_lost_in <= (k == 0);
      internal_fault_flag_in <= (k == 1);
      if (k == 2)
        wr(dioc_pkg::A_CTRL, 32'h0);
      settle(16'h000A, 16'h0000);
      chk("failsafe drive", 16'h000A, pin_out);
      link_lost_in <= 1'b0;
      internal_fault_flag_in <= 1'b0;
      wr(dioc_pkg::A_CTRL, 32'h1);
      settle(16'h0018, 16'h0000);
      chk("resumed drive", 16'h0018, pin_out);
    end
    $display("Test failsafe done");
    wr(dioc_pkg::A_CH0, 32'h2);
    wr(dioc_pkg::A_CH0 + 8'h08, 32'h3);
    wr(dioc_pkg::A_CH0 + 8'h0C, 32'h28);
    wr(dioc_pkg::A_CONS, 32'h0000000F);
    pin_level_in <= 16'h000F;
    settle(16'h000A, 16'h000F);
    chk("mode drive", 16'h000A, pin_out);
    rchk("mode status", dioc_pkg::A_PROD0, 32'h1, '1);
    $display("Test modes done");
    for (int i = 0; i < 4; i++) begin
      {forcing_active_flag_in, internal_fault_flag_in,
        actuator_supply_undervoltage_in,
        sensor_supply_undervoltage_in} <= 4'h1 << i;
      rchk("general diag", dioc_pkg::A_PROD0, {8'h00, gbit[i], 16'h0001},
        '1);
    end
    {forcing_active_flag_in, internal_fault_flag_in} <= 2'h0;
    {actuator_supply_undervoltage_in, sensor_supply_undervoltage_in} <= 2'h0;
    sensor_short_in <= 8'hA5;
    rchk("sensor diag", dioc_pkg::A_PROD1, 32'h000000A5, '1);
    rchk("general short", dioc_pkg::A_PROD0, 32'h00040001, '1);
    sensor_short_in <= 8'h00;
    $display("Test diagnostics done");
    {out_overload_in, out_overcurrent_in} <= 32'hFFFFFFFF;
    repeat (8) @(posedge clk_in);
    {out_overload_in, out_overcurrent_in} <= 32'h0;
    rchk("brief fault silent", dioc_pkg::A_PROD1, 32'h0, '1);
    $display("Test fault filter done");
    wr(dioc_pkg::A_MAP0 + 8'h04, 32'h0);
    rchk("map clash", dioc_pkg::A_STAT, 32'h00010000, 32'h00010000);
    wr(dioc_pkg::A_MAP0 + 8'h04, 32'h1);
    rchk("map clear", dioc_pkg::A_STAT, 32'h0, 32'h00010000);
    $display("Test map done");
    i_plc.rd(8'h3C, v, r);
    chk("unmapped rdata", 32'h0, v);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    i_plc.wr(8'h3C, 32'h1, r);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    $display("Test unmapped done");
    // A one millisecond filter must hold the new level back until it ends.
    wr(dioc_pkg::A_CH0 + 8'h14, 32'h1000);
    pin_level_in <= 16'h002F;
    repeat (dioc_pkg::MS_CYC * 4 / 5) @(posedge clk_in);
    rchk("filter early", dioc_pkg::A_PROD0, 32'h0, 32'h20);
    repeat (dioc_pkg::MS_CYC / 4) @(posedge clk_in);
    rchk("filter late", dioc_pkg::A_PROD0, 32'h20, 32'h20);
    $display("Test input filter done");
    wrap_up;
  end
endmodule // tb

// ===== pkg/dioc_pkg.sv
// Purpose: Shared constants for the sixteen-channel digital I/O controller.
// Assumes: 25 MHz module clock, AXI4-Lite register access, 32-bit data.
// Notes: Mode, failsafe, polarity and filter encodings follow the config.
package dioc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int NCH = 16;
  // Fixed output fault filter, in microseconds, and its cycle count.
  localparam int OUT_FILT_US = 5000;
  localparam int OUT_FILT_CYC = OUT_FILT_US * (CLK_HZ / 1000000);
  // Restart test delay, in microseconds, and its cycle count.
  localparam int RESTART_US = 100000;
  localparam int RESTART_CYC = RESTART_US * (CLK_HZ / 1000000);
  // Surveillance delay unit: one setting step is one millisecond.
  localparam int SURV_UNIT_CYC = CLK_HZ / 1000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam logic [7:0] SURV_RST = 8'h50;
  // Channel mode encodings.
  localparam logic [1:0] MODE_DIO = 2'h0;
  localparam logic [1:0] MODE_DO = 2'h1;
  localparam logic [1:0] MODE_DI = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // Failsafe choices.
  localparam logic [1:0] FS_LOW = 2'h0;
  localparam logic [1:0] FS_HIGH = 2'h1;
  localparam logic [1:0] FS_HOLD = 2'h2;
  localparam logic POL_NO = 1'h0;
  localparam logic POL_NC = 1'h1;
  localparam logic [2:0] ILIM_OFF = 3'h4;
  localparam logic [4:0] MAP_INACTIVE = 5'h10;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CONS = 8'h04;
  localparam logic [7:0] A_PROD0 = 8'h08;
  localparam logic [7:0] A_PROD1 = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_CH0 = 8'h40;
  localparam logic [7:0] A_MAP0 = 8'h80;
  // Per-channel config word fields.
  localparam int F_MODE = 0;
  localparam int F_FS = 2;
  localparam int F_RST = 4;
  localparam int F_POL = 5;
  localparam int F_LIM = 8;
  localparam int F_FILT = 12;
  localparam int F_SURV = 16;
  localparam logic [31:0] CH_RST = 32'h0050_0000;
  localparam int C_RUN = 0;
  localparam int C_VARIANT_DI = 1;
endpackage

// ===== verilog/dioc_top.sv
// Purpose: Channel logic, process images and register slave of the I/O unit.
// Assumes: Pins and analog monitors are asynchronous and get synchronised.
// Notes: Configuration arrives over AXI4-Lite; no interrupts, no buffers.
`timescale 1ns/1ps
// What this block does
// RQ1 - Mask output faults for surveillance delay
// RQ2 - Fixed 5 ms filter on output faults
// RQ3 - Failsafe on error, stop or lost link
// RQ4 - Failsafe drives low, high, or last
// RQ5 - Overload reports diagnosis, switches output off
// RQ6 - Restart mode retries output after delay
// RQ7 - No restart: off until control bit clears
// RQ8 - Over-limit current flags error; max disables
// RQ9 - High-side drives high only, else high-Z
// RQ10 - Normally open passes input uninverted
// RQ11 - Normally closed inverts the input
// RQ12 - Indicator shows raw pin level
// RQ13 - Per-channel input filter or bypass
// RQ14 - Mode selects drive and report roles
// RQ15 - Control word bits drive output channels
// RQ16 - Consuming image: control word plus reserved
// RQ17 - Producing image: four words, 6 for DI (here always four; DI zeroes the actuator word)
// RQ18 - Input status bits valid for inputs only
// RQ19 - General diagnostics byte layout
// RQ20 - Sensor short flags per port
// RQ21 - Actuator diagnostics fixed channel order
// RQ22 - Remap positions; duplicates reject configuration (here only flagged in status; the map is still applied)
// RQ23 - Mode encoding zero to three
// RQ24 - Polarity encoding open zero, closed one
// RQ25 - Filter passes level stable full time
// RQ26 - Delays timed by reset-cleared counters
module dioc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_level_in,
  input wire logic [15:0] out_overload_in,
  input wire logic [15:0] out_overcurrent_in,
  input wire logic [7:0] sensor_short_in,
  input wire logic sensor_supply_undervoltage_in,
  input wire logic actuator_supply_undervoltage_in,
  input wire logic internal_fault_flag_in,
  input wire logic link_lost_in,
  input wire logic forcing_active_flag_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_out,
  output logic [15:0] led_out
);
  localparam int SW = 24;
  // Synchronisers for every asynchronous input; only the second stage is
  // read, so a metastable first stage never reaches the channel logic.
  logic [60:0] raw_in;
  logic [60:0] s1_q;
  logic [60:0] s2_q;
  assign raw_in = {pin_level_in, out_overload_in, out_overcurrent_in,
    sensor_short_in, sensor_supply_undervoltage_in,
    actuator_supply_undervoltage_in, internal_fault_flag_in, link_lost_in,
    forcing_active_flag_in};
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end
  logic [15:0] pin_s, ovl_s, ocur_s;
  logic [7:0] ssc_s;
  logic lvs_s, lva_s, ime_s, lost_s, fme_s;
  assign pin_s = s2_q[60:45];
  assign ovl_s = s2_q[44:29];
  assign ocur_s = s2_q[28:13];
  assign ssc_s = s2_q[12:5];
  assign lvs_s = s2_q[4];
  assign lva_s = s2_q[3];
  assign ime_s = s2_q[2];
  assign lost_s = s2_q[1];
  assign fme_s = s2_q[0];
  // Registers written by software, and the map clash flag.
  logic [31:0] ctrl_q;
  logic [15:0] cons_q;
  logic [31:0] chcfg_q [dioc_pkg::NCH];
  logic [4:0] map_q [dioc_pkg::NCH];
  logic map_err_q;
  // Derived per-channel values and the failsafe flag.
  logic [15:0] is_out, is_in, map_ok_ctl, instat, actdiag;
  logic failsafe;
  logic [15:0] ctl_mapped;
  logic [15:0] last_q;
  // Any one cause is enough; the synchronised copies keep a pin glitch
  // from splitting the decision across channels in one cycle.
  assign failsafe = ime_s | lost_s | ~ctrl_q[dioc_pkg::C_RUN]; // RQ3
  always_comb begin
    ctl_mapped = '0;
    for (int i = 0; i < 16; i++) begin
      is_out[i] = chcfg_q[i][dioc_pkg::F_MODE +: 2] == dioc_pkg::MODE_DIO
        || chcfg_q[i][dioc_pkg::F_MODE +: 2] == dioc_pkg::MODE_DO; // RQ14 RQ23
      is_in[i] = chcfg_q[i][dioc_pkg::F_MODE +: 2] == dioc_pkg::MODE_DIO
        || chcfg_q[i][dioc_pkg::F_MODE +: 2] == dioc_pkg::MODE_DI; // RQ14
      if (map_q[i] != dioc_pkg::MAP_INACTIVE)
        ctl_mapped[i] = cons_q[map_q[i][3:0]]; // RQ15 RQ22
    end
  end
  // Hold-last keeps the most recent control while no failsafe cause is present.
  // It freezes at failsafe entry, so the held value is the pre-fault one.
  always_ff @(posedge clk_in) begin
    if (rst_in) last_q <= '0;
    else if (!failsafe) last_q <= ctl_mapped;
  end
  logic [15:0] want, drive;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      case (chcfg_q[i][dioc_pkg::F_FS +: 2])
        dioc_pkg::FS_LOW: want[i] = failsafe ? 1'b0 : ctl_mapped[i];
        dioc_pkg::FS_HIGH: want[i] = failsafe ? 1'b1 : ctl_mapped[i];
        default: want[i] = failsafe ? last_q[i] : ctl_mapped[i]; // RQ4
      endcase
      want[i] = want[i] & is_out[i];
    end
  end
  // One channel engine per channel keeps the timing logic in one place.
  for (genvar g = 0; g < 16; g++) begin : g_ch
    dioc_chan u_ch (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .want_in(want[g]),
      .cfg_in(chcfg_q[g]),
      .is_out_in(is_out[g]),
      .overload_in(ovl_s[g]),
      .overcurrent_in(ocur_s[g]),
      .pin_in(pin_s[g]),
      .drive_out(drive[g]),
      .err_out(actdiag[g]),
      .di_out(map_ok_ctl[g])
    );
  end
  // High-side stage: enable only while driving high.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_out <= '0;
      led_out <= '0;
    end else begin
      pin_out <= drive;
      pin_oe_out <= drive; // RQ9
      led_out <= pin_s; // RQ12
    end
  end
  // Input status placed at the mapped bit, valid only for inputs.
  always_comb begin
    instat = '0;
    for (int i = 0; i < 16; i++)
      if (is_in[i] && map_q[i] != dioc_pkg::MAP_INACTIVE)
        instat[map_q[i][3:0]] = map_ok_ctl[i]; // RQ18
  end
  logic [15:0] gen_diag;
  assign gen_diag = {8'h00, ime_s, fme_s, 2'b00, |actdiag, |ssc_s,
    lva_s, lvs_s}; // RQ19
  // Producing image registered so readers see one consistent snapshot.
  logic [63:0] prod_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) prod_q <= '0;
    else prod_q <= {(ctrl_q[dioc_pkg::C_VARIANT_DI] ? 16'h0000 : actdiag),
      {8'h00, ssc_s}, gen_diag, instat}; // RQ17 RQ20 RQ21
  end
  // Duplicate positions flag the whole map invalid.
  // The map is still applied while flagged; software must correct it.
  logic dup;
  always_comb begin
    dup = 1'b0;
    for (int i = 0; i < 16; i++)
      for (int j = i + 1; j < 16; j++)
        if (map_q[i] == map_q[j] && map_q[i] != dioc_pkg::MAP_INACTIVE)
          dup = 1'b1;
  end
  // AXI4-Lite write path; address and data may come in either order.
  // Writes to the read-only image words answer with a slave error.
  logic aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  assign s_axi_awready = !aw_h && !s_axi_bvalid;
  assign s_axi_wready = !w_h && !s_axi_bvalid;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= '0;
      w_d <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_q <= '0;
      cons_q <= '0;
      map_err_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        chcfg_q[i] <= dioc_pkg::CH_RST;
        map_q[i] <= 5'(i);
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h <= 1'b1;
        aw_a <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h <= 1'b1;
        w_d <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (aw_h && w_h) begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (aw_a == dioc_pkg::A_CTRL) ctrl_q <= w_d;
        else if (aw_a == dioc_pkg::A_CONS) cons_q <= w_d[15:0]; // RQ16
        else if (aw_a >= dioc_pkg::A_CH0 && aw_a < dioc_pkg::A_MAP0)
          chcfg_q[aw_a[5:2]] <= w_d;
        else if (aw_a >= dioc_pkg::A_MAP0 && aw_a < 8'hC0)
          map_q[aw_a[5:2]] <= w_d[4:0] > 5'h10 ? 5'h10 : w_d[4:0];
        else if (aw_a != dioc_pkg::A_STAT) s_axi_bresp <= 2'b10;
      end
      map_err_q <= dup; // RQ22
    end
  end
  // Read path answers one cycle after the address is taken.
  // Read data is registered so it holds while rvalid waits for rready.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr[7:0])
        dioc_pkg::A_CTRL: s_axi_rdata <= ctrl_q;
        dioc_pkg::A_CONS: s_axi_rdata <= {16'h0000, cons_q};
        dioc_pkg::A_PROD0: s_axi_rdata <= prod_q[31:0];
        dioc_pkg::A_PROD1: s_axi_rdata <= prod_q[63:32];
        dioc_pkg::A_STAT: s_axi_rdata <= {15'h0000, map_err_q, drive};
        default: begin
          if (s_axi_araddr[7:6] == 2'b01)
            s_axi_rdata <= chcfg_q[s_axi_araddr[5:2]];
          else if (s_axi_araddr[7:6] == 2'b10)
            s_axi_rdata <= {27'h0, map_q[s_axi_araddr[5:2]]};
          else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b10;
          end
        end
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule // dioc_top

// Per-channel engine: output protection and input conditioning.
module dioc_chan (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic want_in,
  input wire logic [31:0] cfg_in,
  input wire logic is_out_in,
  input wire logic overload_in,
  input wire logic overcurrent_in,
  input wire logic pin_in,
  output logic drive_out,
  output logic err_out,
  output logic di_out
);
  typedef enum logic [1:0] {ON_S, TRIP_S, RETRY_S} dioc_prot_type;
  dioc_prot_type st_q;
  logic [23:0] surv_q, filt_q, rst_q, dfilt_q;
  logic want_prev_q, di_q, fault_raw, fault_q, dmask;
  logic [23:0] filt_len;
  // Surveillance window from each rising edge of the control.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      want_prev_q <= 1'b0;
      surv_q <= '0;
    end else begin
      want_prev_q <= want_in;
      if (want_in && !want_prev_q)
        surv_q <= 24'(cfg_in[dioc_pkg::F_SURV +: 8]
          * dioc_pkg::SURV_UNIT_CYC); // RQ1 RQ26
      else if (surv_q != 0) surv_q <= surv_q - 24'd1;
    end
  end
  assign dmask = surv_q != 0; // RQ1
  assign fault_raw = is_out_in && (overload_in || (overcurrent_in
    && cfg_in[dioc_pkg::F_LIM +: 3] != dioc_pkg::ILIM_OFF)); // RQ8
  // Fault must persist the fixed filter time before it is reported.
  // The surveillance mask also clears the count, so a masked fault restarts.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      filt_q <= '0;
      fault_q <= 1'b0;
    end else if (!fault_raw || dmask) begin
      filt_q <= '0;
      fault_q <= 1'b0;
    end else if (filt_q == 24'(dioc_pkg::OUT_FILT_CYC - 1)) begin
      fault_q <= 1'b1; // RQ2
    end else filt_q <= filt_q + 24'd1;
  end
  assign err_out = fault_q; // RQ5 RQ21
  // Protection state: trip off, then retry or wait for control clear.
  // A retry lasts one cycle; a fault still latched trips it again.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= ON_S;
      rst_q <= '0;
    end else begin
      case (st_q)
        ON_S: if (fault_q) st_q <= TRIP_S; // RQ5
        TRIP_S: begin
          rst_q <= rst_q + 24'd1;
          if (cfg_in[dioc_pkg::F_RST]) begin
            if (rst_q == 24'(dioc_pkg::RESTART_CYC - 1)) begin
              rst_q <= '0;
              st_q <= RETRY_S; // RQ6 RQ26
            end
          end else if (!want_in) begin
            rst_q <= '0;
            st_q <= ON_S; // RQ7
          end
        end
        RETRY_S: st_q <= ON_S; // RQ6
        default: st_q <= ON_S;
      endcase
    end
  end
  assign drive_out = want_in && st_q != TRIP_S;
  // Filter length from the selection code, in whole milliseconds.
  // Selection code seven is unused and is treated as no filter.
  always_comb begin
    case (cfg_in[dioc_pkg::F_FILT +: 3])
      3'h1: filt_len = 24'(1 * dioc_pkg::MS_CYC);
      3'h2: filt_len = 24'(2 * dioc_pkg::MS_CYC);
      3'h3: filt_len = 24'(3 * dioc_pkg::MS_CYC);
      3'h4: filt_len = 24'(6 * dioc_pkg::MS_CYC);
      3'h5: filt_len = 24'(10 * dioc_pkg::MS_CYC);
      3'h6: filt_len = 24'(15 * dioc_pkg::MS_CYC);
      default: filt_len = 24'h000000;
    endcase
  end
  // Stable-time filter restarts its count on every change.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      di_q <= 1'b0;
      dfilt_q <= '0;
    end else if (filt_len == 0) begin
      di_q <= pin_in; // RQ13
      dfilt_q <= '0;
    end else if (pin_in == di_q) dfilt_q <= '0;
    else if (dfilt_q >= filt_len - 24'd1) begin
      di_q <= pin_in; // RQ25
      dfilt_q <= '0;
    end else dfilt_q <= dfilt_q + 24'd1;
  end
  // Polarity acts after the filter, so the indicator path stays raw.
  assign di_out = cfg_in[dioc_pkg::F_POL] ? ~di_q : di_q; // RQ10 RQ11 RQ24
endmodule // dioc_chan
